// ### timer8_pkg.sv
// Purpose: shared constants and types for the 8-bit compare and waveform timer
// Assumes: one clock domain, timer clock given as a one-cycle enable
// Notes:   enum order follows the waveform mode select encoding
package timer8_pkg;

    localparam int        CNT_W    = 8;
    localparam logic [7:0] BOTTOM  = 8'h00;
    localparam logic [7:0] MAX     = 8'hff;
    localparam logic [7:0] ONE     = 8'h01;
    localparam logic [7:0] CNT_RST = 8'h00;
    localparam logic [7:0] CMP_RST = 8'h00;

    // compare output mode encodings
    localparam logic [1:0] COM_OFF    = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR  = 2'h2;
    localparam logic [1:0] COM_SET    = 2'h3;

    localparam logic OC_RST   = 1'b0;
    localparam logic FLAG_RST = 1'b0;
    localparam logic DIR_UP   = 1'b0;
    localparam logic DIR_DOWN = 1'b1;

    typedef enum logic [1:0] {
        WAVE_NORMAL,
        WAVE_PHASE_PWM,
        WAVE_CTC,
        WAVE_FAST_PWM
    } wave_mode_e;

endpackage : timer8_pkg

// ### wave_if.sv
// Purpose: events and settings passed from the counter to the output generator
// Assumes: all signals on the timer's single clock
// Notes:   match and bottom events are one-cycle pulses qualified by the timer clock enable; force is not
`timescale 1ns/1ps
`default_nettype none
interface wave_if;
    logic                   match_ev;
    logic                   force_ev;
    logic                   bottom_ev;
    logic                   count_up;
    timer8_pkg::wave_mode_e mode;
    logic [1:0]             com;
    logic                   oc;

    modport ctrl (
        output match_ev,
        output force_ev,
        output bottom_ev,
        output count_up,
        output mode,
        output com,
        input  oc
    );

    modport gen (
        input  match_ev,
        input  force_ev,
        input  bottom_ev,
        input  count_up,
        input  mode,
        input  com,
        output oc
    );
endinterface : wave_if
`default_nettype wire

// ### compare_output_gen.sv
// Purpose: holds the compare output state and applies set, clear or toggle
// Assumes: events come from the counter on the same clock
// Notes:   the state is never reset by a mode change, only by RST_B
`timescale 1ns/1ps
`default_nettype none
module compare_output_gen (
    input wire logic clk,
    input wire logic rst_b,
    wave_if.gen      w
);
    logic oc_r;
    logic oc_nxt;

    wire non_pwm = (w.mode == timer8_pkg::WAVE_NORMAL) || (w.mode == timer8_pkg::WAVE_CTC);
    wire fast    = (w.mode == timer8_pkg::WAVE_FAST_PWM);
    wire com_tog = (w.com == timer8_pkg::COM_TOGGLE);
    wire com_clr = (w.com == timer8_pkg::COM_CLEAR);
    wire com_set = (w.com == timer8_pkg::COM_SET);

    // a forced compare acts exactly like a match, outside the pwm modes only
    wire np_ev   = w.match_ev || w.force_ev;
    // at bottom and a match in the same tick, bottom wins so a max compare holds a level
    wire fm_ev   = w.match_ev && !w.bottom_ev;

    wire act_tog = non_pwm ? (np_ev && com_tog)
                 : fast    ? (w.match_ev && com_tog)
                 :           1'b0;
    wire act_clr = non_pwm ? (np_ev && com_clr)
                 : fast    ? ((com_clr && fm_ev) || (com_set && w.bottom_ev))
                 :           (w.match_ev && ((com_clr && w.count_up) ||
                                             (com_set && !w.count_up)));
    wire act_set = non_pwm ? (np_ev && com_set)
                 : fast    ? ((com_clr && w.bottom_ev) || (com_set && fm_ev))
                 :           (w.match_ev && ((com_clr && !w.count_up) ||
                                             (com_set && w.count_up)));

    // com is read live, so a new setting governs the very next match
    assign oc_nxt = act_tog ? ~oc_r
                  : act_set ? 1'b1
                  : act_clr ? 1'b0
                  :           oc_r;

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            oc_r <= timer8_pkg::OC_RST;
        else
            oc_r <= oc_nxt;
    end

    assign w.oc = oc_r;

    a_com_off_hold: assert property (@(posedge clk) disable iff (!rst_b)
        (w.com == timer8_pkg::COM_OFF) |=> $stable(oc_r))
        else $error("compare output changed with output mode off");

    a_ctc_toggle: assert property (@(posedge clk) disable iff (!rst_b)
        (w.mode == timer8_pkg::WAVE_CTC && com_tog && w.match_ev) |=> (oc_r != $past(oc_r)))
        else $error("ctc toggle mode did not toggle on match");

    a_mode_keeps_oc: assert property (@(posedge clk) disable iff (!rst_b)
        ($changed(w.mode) && !w.match_ev && !w.force_ev && !w.bottom_ev) |=> $stable(oc_r))
        else $error("compare output changed on a mode switch");

endmodule : compare_output_gen
`default_nettype wire

// ### timer8_compare_waveform.sv
// Purpose: 8-bit counter, compare unit and waveform output with pin override
// Assumes: TIMER_TICK is a one-cycle timer clock enable from same-clock logic
// Notes:   PIN_OUT and PIN_OE lag the internal state by one clock
//
// Overview of operation
// - force strobe acts as a match outside pwm
// - forced compare leaves flag and counter alone
// - counter write blocks match in next tick
// - output state survives waveform mode changes
// - output mode unbuffered, applies at next match
// - nonzero output mode overrides port value on pin
// - output mode zero takes no action at matches
// - normal mode counts up, wraps max to zero
// - normal overflow flag set as counter hits zero
// - ctc mode clears counter on compare match
// - ctc compare writes immediate, may miss match
// - ctc toggle mode flips output every match
// - ctc overflow flag set passing max to zero
// - fast pwm counts bottom to max, then clears
// - fast pwm clear on match, set at bottom
// - fast pwm overflow flag set at max
// - fast pwm extreme compare values give spike/level
// - fast pwm toggle mode, compare stays buffered
// - compare buffered in pwm, direct otherwise
// - compare match sets flag on the next clock
// - mode one is dual slope phase correct pwm
`timescale 1ns/1ps
`default_nettype none
module timer8_compare_waveform (
    input  wire logic       CLK,
    input  wire logic       RST_B,
    input  wire logic       TIMER_TICK,
    input  wire logic       COUNTER_WRITE,
    input  wire logic [7:0] COUNTER_WDATA,
    input  wire logic       COMPARE_WRITE,
    input  wire logic [7:0] COMPARE_WDATA,
    input  wire logic [1:0] WAVEFORM_MODE_SELECT,
    input  wire logic [1:0] COMPARE_OUTPUT_MODE,
    input  wire logic       FORCE_COMPARE_STROBE,
    input  wire logic       COMPARE_MATCH_FLAG_CLR,
    input  wire logic       OVERFLOW_FLAG_CLR,
    input  wire logic       PORT_OUTPUT_VALUE,
    input  wire logic       OUTPUT_PIN_DIRECTION_BIT,
    output logic      [7:0] COUNTER_VALUE,
    output logic      [7:0] COMPARE_VALUE,
    output logic            COMPARE_MATCH_FLAG,
    output logic            OVERFLOW_FLAG,
    output logic            FORCE_COMPARE_STROBE_RD,
    output logic            COMPARE_OUTPUT,
    output logic            PIN_OUT,
    output logic            PIN_OE
);
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic [7:0] cmp_buf_r;
    logic [7:0] cmp_buf_nxt;
    logic [7:0] cmp_act_r;
    logic [7:0] cmp_act_nxt;
    logic       dir_r;
    logic       dir_nxt;
    logic       block_r;
    logic       block_nxt;
    logic       cmf_r;
    logic       cmf_nxt;
    logic       ovf_r;
    logic       ovf_nxt;
    logic       pin_out_r;
    logic       pin_oe_r;
    logic       force_rd_r;

    timer8_pkg::wave_mode_e mode;

    wave_if w ();

    assign mode = timer8_pkg::wave_mode_e'(WAVEFORM_MODE_SELECT);

    // mode decode
    wire m_normal = (mode == timer8_pkg::WAVE_NORMAL);
    wire m_phase  = (mode == timer8_pkg::WAVE_PHASE_PWM);
    wire m_ctc    = (mode == timer8_pkg::WAVE_CTC);
    wire m_fast   = (mode == timer8_pkg::WAVE_FAST_PWM);
    wire is_pwm   = m_phase || m_fast;

    // counter state decode
    wire at_max   = (cnt_r == timer8_pkg::MAX);
    wire at_bot   = (cnt_r == timer8_pkg::BOTTOM);
    wire cmp_eq   = (cnt_r == cmp_act_r);

    // a write leaves block_r set until the next tick has passed, even if ticks are stopped
    wire match_ev  = TIMER_TICK && cmp_eq && !block_r;
    wire bottom_ev = TIMER_TICK && m_fast && at_max && !COUNTER_WRITE;
    wire force_ev  = FORCE_COMPARE_STROBE && !is_pwm;

    // ctc clears on the match; a compare set below the count is only met after wrapping
    wire ctc_clear = m_ctc && match_ev;

    // dual slope: turn down at max, turn up at bottom
    wire step_down = m_phase && (dir_r == timer8_pkg::DIR_DOWN ? !at_bot : at_max);
    wire [7:0] cnt_inc  = cnt_r + timer8_pkg::ONE;
    wire [7:0] cnt_dec  = cnt_r - timer8_pkg::ONE;
    wire [7:0] cnt_step = ctc_clear ? timer8_pkg::BOTTOM
                        : step_down ? cnt_dec
                        :             cnt_inc;

    // cpu write beats any count or clear
    assign cnt_nxt = COUNTER_WRITE ? COUNTER_WDATA
                   : TIMER_TICK    ? cnt_step
                   :                 cnt_r;

    assign dir_nxt = !m_phase               ? timer8_pkg::DIR_UP
                   : !TIMER_TICK            ? dir_r
                   : (at_max && !at_bot)    ? timer8_pkg::DIR_DOWN
                   : at_bot                 ? timer8_pkg::DIR_UP
                   :                          dir_r;

    assign block_nxt = COUNTER_WRITE ? 1'b1
                     : TIMER_TICK    ? 1'b0
                     :                 block_r;

    // compare value: buffered in pwm modes, direct in normal and ctc
    wire phase_load = TIMER_TICK && m_phase && at_max && (dir_r == timer8_pkg::DIR_UP);
    wire buf_load   = phase_load || bottom_ev;
    assign cmp_buf_nxt = COMPARE_WRITE ? COMPARE_WDATA : cmp_buf_r;
    assign cmp_act_nxt = !is_pwm  ? cmp_buf_nxt
                       : buf_load ? cmp_buf_r
                       :            cmp_act_r;

    // overflow: max to zero in normal and ctc, leaving max in fast pwm, bottom in phase pwm
    wire ovf_wrap  = TIMER_TICK && !COUNTER_WRITE && at_max && (m_normal || m_ctc);
    wire ovf_fast  = TIMER_TICK && m_fast && at_max;
    wire ovf_phase = TIMER_TICK && m_phase && at_bot && (dir_r == timer8_pkg::DIR_DOWN);
    wire ovf_set   = ovf_wrap || ovf_fast || ovf_phase;

    // hardware set wins over a clear in the same cycle; a forced compare never sets it
    assign cmf_nxt = match_ev || (cmf_r && !COMPARE_MATCH_FLAG_CLR);
    assign ovf_nxt = ovf_set  || (ovf_r && !OVERFLOW_FLAG_CLR);

    // any nonzero output mode takes the pin from the port, in every waveform mode
    wire pin_sel = (COMPARE_OUTPUT_MODE != timer8_pkg::COM_OFF) ? w.oc : PORT_OUTPUT_VALUE;

    assign w.match_ev  = match_ev;
    assign w.force_ev  = force_ev;
    assign w.bottom_ev = bottom_ev;
    assign w.count_up  = (dir_r == timer8_pkg::DIR_UP);
    assign w.mode      = mode;
    assign w.com       = COMPARE_OUTPUT_MODE;

    compare_output_gen u_gen (
        .clk   (CLK),
        .rst_b (RST_B),
        .w     (w)
    );

    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            cnt_r     <= timer8_pkg::CNT_RST;
            cmp_buf_r <= timer8_pkg::CMP_RST;
            cmp_act_r <= timer8_pkg::CMP_RST;
            dir_r     <= timer8_pkg::DIR_UP;
            block_r   <= 1'b0;
        end
        else
        begin
            cnt_r     <= cnt_nxt;
            cmp_buf_r <= cmp_buf_nxt;
            cmp_act_r <= cmp_act_nxt;
            dir_r     <= dir_nxt;
            block_r   <= block_nxt;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            cmf_r      <= timer8_pkg::FLAG_RST;
            ovf_r      <= timer8_pkg::FLAG_RST;
            pin_out_r  <= 1'b0;
            pin_oe_r   <= 1'b0;
            force_rd_r <= 1'b0;
        end
        else
        begin
            cmf_r      <= cmf_nxt;
            ovf_r      <= ovf_nxt;
            pin_out_r  <= pin_sel;
            pin_oe_r   <= OUTPUT_PIN_DIRECTION_BIT;
            // the strobe is write-only and never holds a one
            force_rd_r <= 1'b0;
        end
    end

    assign COUNTER_VALUE           = cnt_r;
    assign COMPARE_VALUE           = cmp_buf_r;
    assign COMPARE_MATCH_FLAG      = cmf_r;
    assign OVERFLOW_FLAG           = ovf_r;
    assign FORCE_COMPARE_STROBE_RD = force_rd_r;
    assign COMPARE_OUTPUT          = w.oc;
    assign PIN_OUT                 = pin_out_r;
    assign PIN_OE                  = pin_oe_r;

    // software obligations on counter writes and pin setup are not checked here
    a_write_blocks: assert property (@(posedge CLK) disable iff (!RST_B)
        (COUNTER_WRITE ##1 (TIMER_TICK && !COUNTER_WRITE)) |-> !match_ev)
        else $error("match not blocked after counter write");

    a_force_pure: assert property (@(posedge CLK) disable iff (!RST_B)
        (force_ev && !TIMER_TICK && !COUNTER_WRITE && !cmf_r) |=>
        ($stable(cnt_r) && !cmf_r))
        else $error("forced compare touched counter or match flag");

    a_normal_wrap: assert property (@(posedge CLK) disable iff (!RST_B)
        (TIMER_TICK && m_normal && at_max && !COUNTER_WRITE) |=>
        (COUNTER_VALUE == timer8_pkg::BOTTOM && OVERFLOW_FLAG))
        else $error("normal mode did not wrap with overflow");

    a_ctc_clear: assert property (@(posedge CLK) disable iff (!RST_B)
        (m_ctc && match_ev && !COUNTER_WRITE) |=> (COUNTER_VALUE == timer8_pkg::BOTTOM))
        else $error("ctc mode did not clear counter on match");

    a_fast_restart: assert property (@(posedge CLK) disable iff (!RST_B)
        (TIMER_TICK && m_fast && at_max && !COUNTER_WRITE) |=>
        (COUNTER_VALUE == timer8_pkg::BOTTOM && OVERFLOW_FLAG))
        else $error("fast pwm did not restart from bottom");

    a_ovf_sticky: assert property (@(posedge CLK) disable iff (!RST_B)
        (OVERFLOW_FLAG && !OVERFLOW_FLAG_CLR) |=> OVERFLOW_FLAG)
        else $error("overflow flag dropped without a clear");

    a_match_flag: assert property (@(posedge CLK) disable iff (!RST_B)
        (TIMER_TICK && cmp_eq && !block_r) |=> COMPARE_MATCH_FLAG)
        else $error("compare match flag not set after match");

    a_pin_override: assert property (@(posedge CLK) disable iff (!RST_B)
        (COMPARE_OUTPUT_MODE != timer8_pkg::COM_OFF) |=>
        (PIN_OUT == $past(w.oc) && PIN_OE == $past(OUTPUT_PIN_DIRECTION_BIT)))
        else $error("pin not driven from compare output");

    a_direct_compare: assert property (@(posedge CLK) disable iff (!RST_B)
        (!is_pwm && COMPARE_WRITE) |=> (cmp_act_r == $past(COMPARE_WDATA)))
        else $error("compare write not direct in non-pwm mode");

    a_pwm_no_force: assert property (@(posedge CLK) disable iff (!RST_B)
        (is_pwm && FORCE_COMPARE_STROBE && !match_ev && !bottom_ev) |=>
        ($stable(w.oc) && !FORCE_COMPARE_STROBE_RD))
        else $error("force strobe acted in a pwm mode");

    a_ctc_overflow: assert property (@(posedge CLK) disable iff (!RST_B)
        (TIMER_TICK && m_ctc && at_max && !COUNTER_WRITE) |=> OVERFLOW_FLAG)
        else $error("ctc mode missed overflow at max");

    a_fast_overflow: assert property (@(posedge CLK) disable iff (!RST_B)
        (TIMER_TICK && m_fast && at_max) |=> OVERFLOW_FLAG)
        else $error("fast pwm missed overflow at max");

    a_write_wins: assert property (@(posedge CLK) disable iff (!RST_B)
        COUNTER_WRITE |=> (COUNTER_VALUE == $past(COUNTER_WDATA)))
        else $error("counter write lost to a count or clear");

    a_normal_count: assert property (@(posedge CLK) disable iff (!RST_B)
        (TIMER_TICK && m_normal && !COUNTER_WRITE) |=>
        (COUNTER_VALUE == 8'($past(cnt_r) + timer8_pkg::ONE)))
        else $error("normal mode did not step up by one");

    a_ctc_run_on: assert property (@(posedge CLK) disable iff (!RST_B)
        (TIMER_TICK && m_ctc && !match_ev && !COUNTER_WRITE) |=>
        (COUNTER_VALUE == 8'($past(cnt_r) + timer8_pkg::ONE)))
        else $error("ctc mode cleared without a match");

    a_flag_sticky: assert property (@(posedge CLK) disable iff (!RST_B)
        (COMPARE_MATCH_FLAG && !COMPARE_MATCH_FLAG_CLR) |=> COMPARE_MATCH_FLAG)
        else $error("match flag dropped without a clear");

    a_flag_set_wins: assert property (@(posedge CLK) disable iff (!RST_B)
        (ovf_set && OVERFLOW_FLAG_CLR) |=> OVERFLOW_FLAG)
        else $error("overflow clear beat a set in the same cycle");

    a_pwm_buffered: assert property (@(posedge CLK) disable iff (!RST_B)
        (is_pwm && !buf_load) |=> $stable(cmp_act_r))
        else $error("active compare moved outside top or bottom");

    a_fast_bottom_set: assert property (@(posedge CLK) disable iff (!RST_B)
        (bottom_ev && COMPARE_OUTPUT_MODE == timer8_pkg::COM_CLEAR) |=> w.oc)
        else $error("non-inverting pwm not set at bottom");

    a_fast_bottom_clr: assert property (@(posedge CLK) disable iff (!RST_B)
        (bottom_ev && COMPARE_OUTPUT_MODE == timer8_pkg::COM_SET) |=> !w.oc)
        else $error("inverting pwm not cleared at bottom");

    a_fast_match_clr: assert property (@(posedge CLK) disable iff (!RST_B)
        (m_fast && match_ev && !bottom_ev && COMPARE_OUTPUT_MODE == timer8_pkg::COM_CLEAR)
        |=> !w.oc)
        else $error("non-inverting pwm not cleared on match");

    a_phase_turn: assert property (@(posedge CLK) disable iff (!RST_B)
        (TIMER_TICK && m_phase && at_max && !COUNTER_WRITE) |=>
        (COUNTER_VALUE == 8'(timer8_pkg::MAX - timer8_pkg::ONE)))
        else $error("phase pwm did not turn down at max");

    a_pin_port: assert property (@(posedge CLK) disable iff (!RST_B)
        (COMPARE_OUTPUT_MODE == timer8_pkg::COM_OFF) |=> (PIN_OUT == $past(PORT_OUTPUT_VALUE)))
        else $error("pin not driven from port value with output mode off");

    a_force_toggles: assert property (@(posedge CLK) disable iff (!RST_B)
        (force_ev && !match_ev && COMPARE_OUTPUT_MODE == timer8_pkg::COM_TOGGLE) |=>
        (w.oc != $past(w.oc)))
        else $error("forced compare did not toggle the output");

endmodule : timer8_compare_waveform
`default_nettype wire

// ### pin_load_model.sv
// Purpose: board side of the compare output pin
// Assumes: no pull resistor on the pin
// Notes:   an undriven pin shows the inverse of its last driven level
`timescale 1ns/1ps
`default_nettype none
module pin_load_model (
    input  wire logic clk,
    input  wire logic pin_out,
    input  wire logic pin_oe,
    output logic      pin_level
);
    logic last_r = 1'b0;

    // a floating pin must not look like the value it last held
    always_ff @(posedge clk)
    begin
        if (pin_oe)
            last_r <= pin_out;
    end

    assign pin_level = pin_oe ? pin_out : ~last_r;
endmodule : pin_load_model
`default_nettype wire

// ### timer8_compare_waveform_test.sv
// Purpose: self-checking bench for the compare and waveform timer
// Assumes: timer tick driven every cycle while counting
// Notes:   ticks and frc end one clock after their last strobe; wr_cnt, wr_cmp and clr end just after it is sampled
`timescale 1ns/1ps
`default_nettype none
module timer8_compare_waveform_test;
    logic       CLK = 1'b0;
    logic       RST_B, TIMER_TICK, COUNTER_WRITE, COMPARE_WRITE;
    logic [7:0] COUNTER_WDATA, COMPARE_WDATA, COUNTER_VALUE, COMPARE_VALUE;
    logic [1:0] WAVEFORM_MODE_SELECT, COMPARE_OUTPUT_MODE;
    logic       FORCE_COMPARE_STROBE, COMPARE_MATCH_FLAG_CLR, OVERFLOW_FLAG_CLR;
    logic       PORT_OUTPUT_VALUE, OUTPUT_PIN_DIRECTION_BIT, COMPARE_MATCH_FLAG;
    logic       OVERFLOW_FLAG, FORCE_COMPARE_STROBE_RD, COMPARE_OUTPUT, PIN_OUT, PIN_OE;
    logic       pin_level;
    int         errors = 0;
    int         check_count = 0;
    int         hi;
    logic [1:0] com_tab [4] = '{2'h3, 2'h2, 2'h1, 2'h1};
    logic       oc_tab  [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

    timer8_compare_waveform DUT (.CLK(CLK), .RST_B(RST_B), .TIMER_TICK(TIMER_TICK),
        .COUNTER_WRITE(COUNTER_WRITE), .COUNTER_WDATA(COUNTER_WDATA),
        .COMPARE_WRITE(COMPARE_WRITE), .COMPARE_WDATA(COMPARE_WDATA),
        .WAVEFORM_MODE_SELECT(WAVEFORM_MODE_SELECT), .COMPARE_OUTPUT_MODE(COMPARE_OUTPUT_MODE),
        .FORCE_COMPARE_STROBE(FORCE_COMPARE_STROBE),
        .COMPARE_MATCH_FLAG_CLR(COMPARE_MATCH_FLAG_CLR), .OVERFLOW_FLAG_CLR(OVERFLOW_FLAG_CLR),
        .PORT_OUTPUT_VALUE(PORT_OUTPUT_VALUE),
        .OUTPUT_PIN_DIRECTION_BIT(OUTPUT_PIN_DIRECTION_BIT),
        .COUNTER_VALUE(COUNTER_VALUE), .COMPARE_VALUE(COMPARE_VALUE),
        .COMPARE_MATCH_FLAG(COMPARE_MATCH_FLAG), .OVERFLOW_FLAG(OVERFLOW_FLAG),
        .FORCE_COMPARE_STROBE_RD(FORCE_COMPARE_STROBE_RD), .COMPARE_OUTPUT(COMPARE_OUTPUT),
        .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE));

    pin_load_model u_pin (.clk(CLK), .pin_out(PIN_OUT), .pin_oe(PIN_OE), .pin_level(pin_level));

    initial
    begin
        forever #2.5 CLK = ~CLK;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic idle(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask : idle

    task automatic ticks(input int n);
        repeat (n)
        begin
            @(posedge CLK);
            TIMER_TICK <= 1'b1;
        end
        @(posedge CLK);
        TIMER_TICK <= 1'b0;
        idle(1);
    endtask : ticks

    task automatic wr_cnt(input logic [7:0] v);
        @(posedge CLK);
        COUNTER_WRITE <= 1'b1;
        COUNTER_WDATA <= v;
        @(posedge CLK);
        COUNTER_WRITE <= 1'b0;
        #1;
    endtask : wr_cnt

    task automatic wr_cmp(input logic [7:0] v);
        @(posedge CLK);
        COMPARE_WRITE <= 1'b1;
        COMPARE_WDATA <= v;
        @(posedge CLK);
        COMPARE_WRITE <= 1'b0;
        #1;
    endtask : wr_cmp

    task automatic frc();
        @(posedge CLK);
        FORCE_COMPARE_STROBE <= 1'b1;
        @(posedge CLK);
        FORCE_COMPARE_STROBE <= 1'b0;
        idle(1);
    endtask : frc

    task automatic clr();
        @(posedge CLK);
        COMPARE_MATCH_FLAG_CLR <= 1'b1;
        OVERFLOW_FLAG_CLR      <= 1'b1;
        @(posedge CLK);
        COMPARE_MATCH_FLAG_CLR <= 1'b0;
        OVERFLOW_FLAG_CLR      <= 1'b0;
        #1;
    endtask : clr

    task automatic set_mode(input logic [1:0] m, input logic [1:0] c);
        @(posedge CLK);
        WAVEFORM_MODE_SELECT <= m;
        COMPARE_OUTPUT_MODE  <= c;
        idle(1);
    endtask : set_mode

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        #60000;
        errors++;
        $display("ERROR at %0t: watchdog expired", $time);
        tally_and_finish();
    end

    initial
    begin
        {RST_B, TIMER_TICK, COUNTER_WRITE, COMPARE_WRITE, FORCE_COMPARE_STROBE} = '0;
        {COUNTER_WDATA, COMPARE_WDATA, WAVEFORM_MODE_SELECT, COMPARE_OUTPUT_MODE} = '0;
        {COMPARE_MATCH_FLAG_CLR, OVERFLOW_FLAG_CLR} = '0;
        {PORT_OUTPUT_VALUE, OUTPUT_PIN_DIRECTION_BIT} = '0;
        repeat (20) @(posedge CLK);
        RST_B <= 1'b1;
        idle(2);
        chk({COUNTER_VALUE, COMPARE_VALUE}, 16'h0000, "reset registers");
        chk({COMPARE_MATCH_FLAG, OVERFLOW_FLAG, COMPARE_OUTPUT, PIN_OE}, 16'h0, "reset bits");
        $display("test reset done");

        frc();
        chk(COMPARE_OUTPUT, 16'h0, "force with output off");
        for (int i = 0; i < 4; i++)
        begin
            set_mode(2'h0, com_tab[i]);
            frc();
            chk({COMPARE_OUTPUT, COMPARE_MATCH_FLAG, FORCE_COMPARE_STROBE_RD},
                {13'h0, oc_tab[i], 2'b00}, "forced compare");
        end
        chk(COUNTER_VALUE, 16'h0, "counter after force");
        set_mode(2'h0, timer8_pkg::COM_SET);
        frc();
        @(posedge CLK);
        OUTPUT_PIN_DIRECTION_BIT <= 1'b1;
        idle(3);
        chk({PIN_OE, pin_level}, 16'h3, "pin shows output state");
        set_mode(2'h0, timer8_pkg::COM_OFF);
        idle(2);
        chk(pin_level, 16'h0, "pin shows port value");
        @(posedge CLK);
        PORT_OUTPUT_VALUE <= 1'b1;
        idle(2);
        chk(pin_level, 16'h1, "pin follows port value");
        $display("test force done");

        clr();
        wr_cnt(8'hfd);
        ticks(2);
        chk({COUNTER_VALUE, OVERFLOW_FLAG}, 16'h1fe, "count to max");
        ticks(1);
        chk({COUNTER_VALUE, OVERFLOW_FLAG, COMPARE_MATCH_FLAG}, 16'h2, "wrap");
        ticks(1);
        chk({COMPARE_MATCH_FLAG, COMPARE_OUTPUT}, 16'h3, "match at zero");
        wr_cmp(8'h10);
        clr();
        wr_cnt(8'h10);
        idle(5);
        ticks(1);
        chk({COUNTER_VALUE, COMPARE_MATCH_FLAG}, 16'h22, "blocked match");
        wr_cnt(8'h0f);
        ticks(2);
        chk(COMPARE_MATCH_FLAG, 16'h1, "match after block");
        $display("test normal done");

        set_mode(2'h2, timer8_pkg::COM_TOGGLE);
        wr_cmp(8'h03);
        clr();
        wr_cnt(8'h00);
        ticks(4);
        chk({COUNTER_VALUE, COMPARE_MATCH_FLAG, COMPARE_OUTPUT}, 16'h2, "ctc clear");
        ticks(4);
        chk({COUNTER_VALUE, COMPARE_OUTPUT}, 16'h1, "ctc toggle");
        set_mode(2'h2, timer8_pkg::COM_CLEAR);
        chk(COMPARE_OUTPUT, 16'h1, "mode write alone");
        wr_cnt(8'h05);
        wr_cmp(8'h02);
        clr();
        ticks(251);
        chk({COUNTER_VALUE, OVERFLOW_FLAG}, 16'h1, "ctc overflow");
        chk(COMPARE_MATCH_FLAG, 16'h0, "missed match");
        ticks(3);
        chk({COUNTER_VALUE, COMPARE_MATCH_FLAG, COMPARE_OUTPUT}, 16'h2, "late match");
        set_mode(2'h2, timer8_pkg::COM_SET);
        frc();
        chk(COMPARE_OUTPUT, 16'h1, "ctc force set");
        $display("test ctc done");

        set_mode(2'h3, timer8_pkg::COM_SET);
        chk(COMPARE_OUTPUT, 16'h1, "state kept over mode change");
        wr_cnt(8'h10);
        wr_cmp(8'h80);
        chk(COMPARE_VALUE, 16'h80, "buffer readback");
        frc();
        clr();
        chk({COMPARE_OUTPUT, FORCE_COMPARE_STROBE_RD}, 16'h2, "force ignored");
        ticks(240);
        chk({COUNTER_VALUE, OVERFLOW_FLAG, COMPARE_MATCH_FLAG}, 16'h2, "fast wrap");
        chk(COMPARE_OUTPUT, 16'h0, "cleared at bottom");
        ticks(129);
        chk({COUNTER_VALUE, COMPARE_MATCH_FLAG, COMPARE_OUTPUT}, 16'h207, "set at match");
        for (int k = 0; k < 2; k++)
        begin
            set_mode(2'h3, timer8_pkg::COM_CLEAR);
            wr_cmp(k == 0 ? 8'hff : 8'h00);
            wr_cnt(8'hff);
            ticks(1);
            hi = 0;
            repeat (256)
            begin
                ticks(1);
                hi += (COMPARE_OUTPUT === 1'b1);
            end
            chk(16'(hi), k == 0 ? 16'd256 : 16'd1, "extreme compare");
        end
        set_mode(2'h3, timer8_pkg::COM_TOGGLE);
        wr_cmp(8'h05);
        ticks(1);
        chk({COUNTER_VALUE, COMPARE_OUTPUT}, 16'h2, "toggle on buffered compare");
        $display("test fast pwm done");

        set_mode(2'h1, timer8_pkg::COM_CLEAR);
        wr_cnt(8'hfd);
        ticks(3);
        chk(COUNTER_VALUE, 16'hfe, "dual slope turn");
        wr_cnt(8'h06);
        ticks(2);
        chk({COUNTER_VALUE, COMPARE_OUTPUT}, 16'h9, "set on match counting down");
        $display("test phase pwm done");
        tally_and_finish();
    end
endmodule : timer8_compare_waveform_test
`default_nettype wire
